// >>> common/dbcmd_pkg.sv
package dbcmd_pkg;

   // ***************************************************************
   // Block identifiers and request block layout.
   // ***************************************************************
   localparam logic [15:0] ID_MASK    = 16'h26d4;   // 9940.
   localparam logic [15:0] ID_FORCE   = 16'h26d5;   // 9941.
   localparam logic [15:0] ID_WARM    = 16'h270e;   // 9998.
   localparam logic [15:0] ID_COLD    = 16'h270f;   // 9999.
   localparam int          BLK_WORDS  = 64;
   localparam logic [5:0]  W_ID       = 6'h00;
   localparam logic [5:0]  W_COUNT    = 6'h01;
   localparam logic [5:0]  W_START    = 6'h02;
   localparam logic [5:0]  W_DATA     = 6'h03;
   localparam logic [6:0]  MAX_MASK   = 7'h1e;      // 30 word pairs.
   localparam logic [6:0]  MAX_FORCE  = 7'h3c;      // 60 words.
   localparam int          DB_WORDS   = 10000;
   localparam logic [13:0] DB_LAST    = 14'h270f;   // Offset 9999.
   localparam logic [7:0]  SID_BCAST  = 8'hff;

   // ***************************************************************
   // APB byte addresses.
   // ***************************************************************
   localparam logic [9:0]  A_BLK      = 10'h000;    // 64 words.
   localparam logic [9:0]  A_RSP0     = 10'h100;
   localparam logic [9:0]  A_RSP1     = 10'h104;
   localparam logic [9:0]  A_CTRL     = 10'h108;
   localparam logic [9:0]  A_CFG      = 10'h10c;
   localparam logic [9:0]  A_RSPDLY   = 10'h110;
   localparam logic [9:0]  A_RTSON    = 10'h114;
   localparam logic [9:0]  A_RTSOFF   = 10'h118;
   localparam logic [9:0]  A_TMO      = 10'h11c;
   localparam logic [9:0]  A_RETRY    = 10'h120;
   localparam logic [9:0]  A_ENQ      = 10'h124;
   localparam logic [9:0]  A_CMDDLY   = 10'h128;
   localparam logic [9:0]  A_ERRSKIP  = 10'h12c;
   localparam logic [9:0]  A_BAUD     = 10'h130;
   localparam logic [9:0]  A_DBADDR   = 10'h134;
   localparam logic [9:0]  A_DBDATA   = 10'h138;
   localparam logic [9:0]  A_STAT     = 10'h13c;

   // ***************************************************************
   // Reset values and timing.
   // ***************************************************************
   localparam logic [15:0] RST_BAUD   = 16'h4b00;   // 19200.
   localparam logic [15:0] RST_TMO    = 16'h03e8;   // 1000 ms.
   localparam logic [15:0] RST_RETRY  = 16'h0003;
   localparam logic [15:0] RST_ENQ    = 16'h000a;
   localparam logic [15:0] RST_CMDDLY = 16'h000a;
   localparam logic [15:0] RST_ERRSKP = 16'h0064;
   localparam logic [15:0] RST_RTSOFF = 16'h0001;
   localparam int          MS_NS      = 1000000;
   localparam int          CLK_NS     = 10;
   localparam int          CYC_PER_MS = MS_NS / CLK_NS;

   // ***************************************************************
   // Port configuration word, bit 31 downward.
   // ***************************************************************
   typedef struct packed
   {
      logic [7:0] station_id;  // 31:24, 0 to 254.
      logic [12:0] rsvd;       // 23:11.
      logic       use_cts;     // 10.
      logic       two_stop;    // 9.
      logic [1:0] data_bits;   // 8:7, 0=5 .. 3=8.
      logic [2:0] parity;      // 6:4, 0 none 1 odd 2 even 3 mark 4 space.
      logic       crc;         // 3, else block check character.
      logic       half_duplex; // 2.
      logic       master;      // 1.
      logic       enable;      // 0.
   } dbcmd_cfg_t;

   localparam logic [31:0] RST_CFG    = 32'h0000_0183;
endpackage

// >>> hdl/dbcmd_top.sv
`timescale 1ns/1ps
`default_nettype none

module dbcmd_top
   #(parameter int MS_CYC = dbcmd_pkg::CYC_PER_MS)
(
   // Clock and reset.
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   // APB slave.
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [9:0]             paddr,
   input  wire logic [31:0]            pwdata,
   output var  logic [31:0]            prdata,
   output var  logic                   pready,
   output var  logic                   pslverr,
   // Serial engine handshake, same clock.
   input  wire logic                   msg_req,
   input  wire logic                   msg_enq,
   input  wire logic                   tx_done,
   input  wire logic                   rsp_ok,
   input  wire logic                   cts_pin,
   output var  logic                   tx_start,
   output var  logic                   rts,
   output var  logic                   msg_fail,
   output var  logic                   msg_skipped,
   // Port settings and module control.
   output var  dbcmd_pkg::dbcmd_cfg_t  port_cfg,
   output var  logic [15:0]            baud_rate,
   output var  logic                   reboot
);
   import dbcmd_pkg::*;

   // ***************************************************************
   // Storage.
   // ***************************************************************
   logic [15:0] blk_mem [BLK_WORDS];  // Request block from the host.
   logic [15:0] db_mem  [DB_WORDS];   // Internal database.
   logic [15:0] rsp0_reg;             // Response word 0.
   logic [15:0] rsp1_reg;             // Response word 1.
   logic [15:0] rsp_dly_reg, rtson_reg, rtsoff_reg, tmo_reg;
   logic [15:0] retry_reg, enq_reg, cmddly_reg, errskip_reg;
   logic [13:0] dbaddr_reg;           // Software window into database.
   logic        cfg_err_reg;          // Last station id was refused.
   logic [6:0]  pst_code;             // Port state for the status word.

   // ***************************************************************
   // Command engine state.
   // ***************************************************************
   typedef enum logic [3:0]
   {
      C_IDLE = 4'b0001,
      C_RUN  = 4'b0010,
      C_CLR  = 4'b0100,
      C_BOOT = 4'b1000
   } dbcmd_cst_t;

   dbcmd_cst_t  cst_reg;
   logic        go_reg;       // Software asked to process the block.
   logic [15:0] id_reg;       // Identifier being processed.
   logic [6:0]  idx_reg;      // Words done so far.
   logic [6:0]  cnt_reg;      // Words to do.
   logic [13:0] ptr_reg;      // Current database offset.
   logic [13:0] clr_reg;      // Clear sweep position.

   // ***************************************************************
   // APB decode.
   // ***************************************************************
   wire         setup    = psel & ~penable & ~pready;
   wire         acc      = psel & penable & pready;
   wire         wr       = acc & pwrite;
   wire         in_blk   = (paddr[9:8] == A_BLK[9:8]);
   wire  [5:0]  blk_idx  = paddr[7:2];
   wire         wr_blk   = wr & in_blk;
   wire         hit      = in_blk || (paddr >= A_RSP0 && paddr <= A_STAT
                           && paddr[1:0] == 2'b00);
   wire         busy     = (cst_reg != C_IDLE) | go_reg;
   wire         wr_ctrl  = wr & (paddr == A_CTRL) & pwdata[0];
   wire         sid_ok   = (pwdata[31:24] != SID_BCAST);
   wire         wr_cfg   = wr & (paddr == A_CFG);
   wire         wr_dbd   = wr & (paddr == A_DBDATA)
                           & (dbaddr_reg <= DB_LAST) & (cst_reg != C_CLR);

   // Decoded fields of the request block for the engine.
   wire  [15:0] blk_id    = blk_mem[W_ID];
   wire  [15:0] blk_cnt   = blk_mem[W_COUNT];
   wire  [15:0] blk_start = blk_mem[W_START];
   wire         is_mask   = (id_reg == ID_MASK);

   // Count limits clip an oversize request to the documented maximum.
   function automatic logic [6:0] clip(input logic [15:0] v,
                                       input logic [6:0]  lim);
      clip = (v > {9'h000, lim}) ? lim : v[6:0];
   endfunction

   // Word index into the block for the current target word.
   wire  [6:0]  w_and  = 7'(W_DATA) + {idx_reg[5:0], 1'b0};
   wire  [6:0]  w_frc  = 7'(W_DATA) + idx_reg;
   wire  [15:0] and_m  = blk_mem[w_and[5:0]];
   wire  [15:0] or_m   = blk_mem[6'(w_and[5:0] + 6'h01)];
   wire  [15:0] old_v  = db_mem[ptr_reg];
   wire  [15:0] new_v  = is_mask ? ((old_v & and_m) | or_m)
                                 : blk_mem[w_frc[5:0]];
   wire         eng_wr = (cst_reg == C_RUN) & (idx_reg < cnt_reg)
                         & (ptr_reg <= DB_LAST);

   // Read mux for the APB data path.
   logic [31:0] rd_val;
   always_comb
   begin
      rd_val = 32'h0000_0000;
      if (in_blk)
         rd_val = {16'h0000, blk_mem[blk_idx]};
      else
         case (paddr)
            A_RSP0:    rd_val = {16'h0000, rsp0_reg};
            A_RSP1:    rd_val = {16'h0000, rsp1_reg};
            A_CTRL:    rd_val = {31'h0000_0000, busy};
            A_CFG:     rd_val = port_cfg;
            A_RSPDLY:  rd_val = {16'h0000, rsp_dly_reg};
            A_RTSON:   rd_val = {16'h0000, rtson_reg};
            A_RTSOFF:  rd_val = {16'h0000, rtsoff_reg};
            A_TMO:     rd_val = {16'h0000, tmo_reg};
            A_RETRY:   rd_val = {16'h0000, retry_reg};
            A_ENQ:     rd_val = {16'h0000, enq_reg};
            A_CMDDLY:  rd_val = {16'h0000, cmddly_reg};
            A_ERRSKIP: rd_val = {16'h0000, errskip_reg};
            A_BAUD:    rd_val = {16'h0000, baud_rate};
            A_DBADDR:  rd_val = {18'h00000, dbaddr_reg};
            A_DBDATA:  rd_val = (dbaddr_reg <= DB_LAST)
                                ? {16'h0000, db_mem[dbaddr_reg]}
                                : 32'h0000_0000;
            A_STAT:    rd_val = {24'h000000, pst_code, cfg_err_reg};
            default:   rd_val = 32'h0000_0000;
         endcase
   end

   // ***************************************************************
   // APB handshake: no wait state, data captured in the setup cycle.
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= setup;
         pslverr <= setup & ~hit;
         prdata  <= setup ? rd_val : 32'h0000_0000;
      end
   end

   // ***************************************************************
   // Configuration registers written by software.
   // ***************************************************************
   // A station id of 255 is the broadcast address, so the whole write
   // is refused and flagged; the old settings stay in force.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port_cfg    <= RST_CFG;
         cfg_err_reg <= 1'b0;
         baud_rate   <= RST_BAUD;
         rsp_dly_reg <= 16'h0000;
         rtson_reg   <= 16'h0000;
         rtsoff_reg  <= RST_RTSOFF;
         tmo_reg     <= RST_TMO;
         retry_reg   <= RST_RETRY;
         enq_reg     <= RST_ENQ;
         cmddly_reg  <= RST_CMDDLY;
         errskip_reg <= RST_ERRSKP;
         dbaddr_reg  <= 14'h0000;
      end
      else if (wr)
      begin
         if (wr_cfg)
         begin
            cfg_err_reg <= ~sid_ok;
            if (sid_ok)
               port_cfg <= {pwdata[31:24], 13'h0000,
                            pwdata[10:9],
                            pwdata[8:4],
                            pwdata[3],
                            pwdata[2:0]};
         end
         case (paddr)
            A_BAUD:    baud_rate   <= pwdata[15:0];
            A_RSPDLY:  rsp_dly_reg <= pwdata[15:0];
            A_RTSON:   rtson_reg   <= pwdata[15:0];
            A_RTSOFF:  rtsoff_reg  <= pwdata[15:0];
            A_TMO:     tmo_reg     <= pwdata[15:0];
            A_RETRY:   retry_reg   <= pwdata[15:0];
            A_ENQ:     enq_reg     <= pwdata[15:0];
            A_CMDDLY:  cmddly_reg  <= pwdata[15:0];
            A_ERRSKIP: errskip_reg <= pwdata[15:0];
            A_DBADDR:  dbaddr_reg  <= pwdata[13:0];
            default:   dbaddr_reg  <= dbaddr_reg;
         endcase
      end
   end

   // ***************************************************************
   // Request block and database storage.
   // ***************************************************************
   // The database only changes on an explicit write, so a bit set by
   // the remote side stays until a mask, force, warm or cold block or a software data write clears it.
   always_ff @(posedge pclk)
   begin
      if (cst_reg == C_CLR)
         db_mem[clr_reg] <= 16'h0000;
      else if (eng_wr)
         db_mem[ptr_reg] <= new_v;
      else if (wr_dbd)
         db_mem[dbaddr_reg] <= pwdata[15:0];
   end

   always_ff @(posedge pclk)
   begin
      if (cst_reg == C_CLR)
         blk_mem[clr_reg[5:0]] <= 16'h0000;
      else if (wr_blk)
         blk_mem[blk_idx] <= pwdata[15:0];
   end

   // ***************************************************************
   // Command engine: one database word per clock.
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cst_reg  <= C_IDLE;
         go_reg   <= 1'b0;
         id_reg   <= 16'h0000;
         idx_reg  <= 7'h00;
         cnt_reg  <= 7'h00;
         ptr_reg  <= 14'h0000;
         clr_reg  <= 14'h0000;
         rsp0_reg <= 16'h0000;
         rsp1_reg <= 16'h0000;
         reboot   <= 1'b0;
      end
      else
      begin
         if (wr_ctrl)
            go_reg <= 1'b1;
         reboot <= 1'b0;
         case (cst_reg)
            C_IDLE:
            begin
               if (go_reg && !wr_ctrl)
               begin
                  go_reg  <= 1'b0;
                  id_reg  <= blk_id;
                  idx_reg <= 7'h00;
                  ptr_reg <= (blk_start > {2'b00, DB_LAST})
                             ? DB_LAST + 14'h0001 : blk_start[13:0];
                  cnt_reg <= (blk_id == ID_MASK)
                             ? clip(blk_cnt, MAX_MASK)
                             : clip(blk_cnt, MAX_FORCE);
                  clr_reg <= 14'h0000;
                  if (blk_id == ID_MASK || blk_id == ID_FORCE)
                     cst_reg <= C_RUN;
                  else if (blk_id == ID_WARM || blk_id == ID_COLD)
                     cst_reg <= C_CLR;
               end
            end
            C_RUN:
            begin
               if (idx_reg < cnt_reg)
               begin
                  idx_reg <= idx_reg + 7'h01;
                  ptr_reg <= (ptr_reg > DB_LAST)
                             ? ptr_reg : ptr_reg + 14'h0001;
               end
               else
               begin
                  rsp0_reg <= id_reg;
                  rsp1_reg <= id_reg;
                  cst_reg  <= C_IDLE;
               end
            end
            C_CLR:
            begin
               clr_reg <= clr_reg + 14'h0001;
               if (clr_reg == DB_LAST)
               begin
                  rsp0_reg <= 16'h0000;
                  rsp1_reg <= 16'h0000;
                  cst_reg  <= C_BOOT;
               end
            end
            C_BOOT:
            begin
               reboot  <= 1'b1;
               cst_reg <= C_IDLE;
            end
            default: cst_reg <= C_IDLE;
         endcase
      end
   end

   // ***************************************************************
   // Port timing sequencer.
   // ***************************************************************
   typedef enum logic [6:0]
   {
      P_IDLE   = 7'b0000001,
      P_GAP    = 7'b0000010,
      P_RTSON  = 7'b0000100,
      P_CTS    = 7'b0001000,
      P_SEND   = 7'b0010000,
      P_RTSOFF = 7'b0100000,
      P_WAIT   = 7'b1000000
   } dbcmd_pst_t;

   dbcmd_pst_t  pst_reg;
   logic [31:0] tick_reg;   // Cycles within the current millisecond.
   logic [15:0] ms_reg;     // Milliseconds elapsed in this state.
   logic [15:0] try_reg;    // Retries used on this command.
   logic [15:0] skip_reg;   // Commands still to skip after a failure.
   logic        enq_reg_q;  // Current message is an enquiry.
   logic        cts_s1, cts_s2;

   assign pst_code = pst_reg;

   wire tick   = (tick_reg == 32'(MS_CYC - 1));
   wire cts_ok = ~port_cfg.use_cts | cts_s2;
   wire to_hit = tick & (ms_reg + 16'h0001 >= tmo_reg);

   // Pre-send gap: slaves wait the response delay, half duplex polls
   // wait the enquiry delay, new commands wait the command spacing.
   // Retries skip the spacing, which keeps a failing poll short.
   function automatic logic [15:0] gap(input logic retry,
                                       input logic enq);
      if (!port_cfg.master)
         gap = rsp_dly_reg;
      else if (enq && port_cfg.half_duplex)
         gap = enq_reg;
      else if (retry)
         gap = 16'h0000;
      else
         gap = cmddly_reg;
   endfunction

   // Delay done once the millisecond count reaches its limit.
   function automatic logic done(input logic [15:0] lim);
      done = (ms_reg >= lim);
   endfunction

   // Clear-to-send is a pin, so it passes two flops first.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cts_s1 <= 1'b0;
         cts_s2 <= 1'b0;
      end
      else
      begin
         cts_s1 <= cts_pin;
         cts_s2 <= cts_s1;
      end
   end

   // Millisecond base restarts with each state change.
   dbcmd_pst_t pst_next;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tick_reg <= 32'h0000_0000;
         ms_reg   <= 16'h0000;
      end
      else if (pst_next != pst_reg)
      begin
         tick_reg <= 32'h0000_0000;
         ms_reg   <= 16'h0000;
      end
      else
      begin
         tick_reg <= tick ? 32'h0000_0000 : tick_reg + 32'h0000_0001;
         if (tick && ms_reg != 16'hffff)
            ms_reg <= ms_reg + 16'h0001;
      end
   end

   // Next state of the sequencer.
   always_comb
   begin
      pst_next = pst_reg;
      case (pst_reg)
         P_IDLE:   if (msg_req && port_cfg.enable && skip_reg == 16'h0000)
                      pst_next = P_GAP;
         P_GAP:    if (done(gap(try_reg != 16'h0000, enq_reg_q)))
                      pst_next = P_RTSON;
         P_RTSON:  if (done(rtson_reg))
                      pst_next = P_CTS;
         P_CTS:    if (cts_ok)
                      pst_next = P_SEND;
         P_SEND:   if (tx_done)
                      pst_next = P_RTSOFF;
         P_RTSOFF: if (done(rtsoff_reg))
                      pst_next = port_cfg.master ? P_WAIT : P_IDLE;
         P_WAIT:   if (rsp_ok)
                      pst_next = P_IDLE;
                   else if (to_hit)
                      pst_next = (try_reg < retry_reg) ? P_GAP : P_IDLE;
         default:  pst_next = P_IDLE;
      endcase
      if (!port_cfg.enable)
         pst_next = P_IDLE;
   end

   // Sequencer registers and outputs toward the serial engine.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pst_reg     <= P_IDLE;
         try_reg     <= 16'h0000;
         skip_reg    <= 16'h0000;
         enq_reg_q   <= 1'b0;
         rts         <= 1'b0;
         tx_start    <= 1'b0;
         msg_fail    <= 1'b0;
         msg_skipped <= 1'b0;
      end
      else
      begin
         pst_reg     <= pst_next;
         tx_start    <= (pst_reg == P_CTS) & cts_ok & port_cfg.enable;
         rts         <= (pst_next == P_RTSON) | (pst_next == P_CTS)
                        | (pst_next == P_SEND) | (pst_next == P_RTSOFF);
         msg_fail    <= 1'b0;
         msg_skipped <= 1'b0;
         if (pst_reg == P_IDLE && msg_req && port_cfg.enable)
         begin
            enq_reg_q <= msg_enq;
            try_reg   <= 16'h0000;
            if (skip_reg != 16'h0000 && port_cfg.master)
            begin
               skip_reg    <= skip_reg - 16'h0001;
               msg_skipped <= 1'b1;
            end
         end
         if (pst_reg == P_WAIT && !rsp_ok && to_hit && port_cfg.enable)
         begin
            if (try_reg < retry_reg)
               try_reg <= try_reg + 16'h0001;
            else
            begin
               msg_fail <= 1'b1;
               skip_reg <= errskip_reg;
            end
         end
      end
   end

endmodule

`default_nettype wire

// >>> testbench/dbcmd_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dbcmd_monitor
   import dbcmd_pkg::*;
   #(parameter int MS_CYC = 10)
(
   // Observed ports of the top module.
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [31:0] prdata,
   input wire logic        tx_start,
   input wire logic        rts,
   input wire logic        reboot,
   input wire dbcmd_cfg_t  port_cfg
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // The setup phase of a bus transfer.
   sequence s_setup; psel && !penable; endsequence
   property p_ans; s_setup |=> pready; endproperty
   a_ans: assert property (p_ans) else $error("answer late");
   property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
   a_err: assert property (p_err) else $error("error read not zero");
   property p_txp; tx_start |=> !tx_start; endproperty
   a_txp: assert property (p_txp) else $error("start too long");
   property p_txr; tx_start |-> rts; endproperty
   a_txr: assert property (p_txr) else $error("send without rts");
   property p_sid; port_cfg.station_id != SID_BCAST; endproperty
   a_sid: assert property (p_sid) else $error("broadcast id");
   property p_dis; !port_cfg.enable |-> ##[0:2] !rts; endproperty
   a_dis: assert property (p_dis) else $error("idle port rts");
   property p_rb; reboot |=> !reboot; endproperty
   a_rb: assert property (p_rb) else $error("reboot too long");
   property p_rdy; pready |=> !pready; endproperty
   a_rdy: assert property (p_rdy) else $error("ready too long");
endmodule
`default_nettype wire

// >>> testbench/dbcmd_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module dbcmd_engine_model
(
   // Clock, reset and handshake.
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic tx_start,
   output var  logic tx_done,
   output var  logic rsp_ok,
   output var  logic cts_pin
);
   logic [4:0] step_reg; // Cycles since the send began.
   // Ends the send after four cycles; answers at twenty, once a one
   // millisecond RTS off time of ten cycles is over and the port waits.
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         step_reg <= 5'h00;
      else if (tx_start || step_reg != 5'h00)
         step_reg <= step_reg + 5'h01;
   assign tx_done = (step_reg == 5'h04);
   assign rsp_ok  = (step_reg == 5'h14);
   assign cts_pin = 1'b1;
endmodule
`default_nettype wire

// >>> testbench/dbcmd_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dbcmd_tb_top;
   import dbcmd_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic msg_req = 0, tx_start, rts, reboot, pready, pslverr, er;
   logic tx_done, rsp_ok, cts_pin;
   logic [9:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rv;
   int failures = 0, cmp_count = 0, cyc = 0, boots = 0, i;
   always #5 pclk = ~pclk;
   dbcmd_top #(.MS_CYC(10)) DUT (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .msg_req(msg_req), .msg_enq(1'b0),
      .tx_done(tx_done), .rsp_ok(rsp_ok), .cts_pin(cts_pin),
      .tx_start(tx_start), .rts(rts), .msg_fail(), .msg_skipped(),
      .port_cfg(), .baud_rate(), .reboot(reboot));
   dbcmd_engine_model eng (.pclk(pclk), .presetn(presetn),
      .tx_start(tx_start), .tx_done(tx_done), .rsp_ok(rsp_ok),
      .cts_pin(cts_pin));
   task automatic give_verdict;
      $display("compares %0d bad %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // One bus transfer; the request holds until ready is seen.
   task automatic apb(input logic w, input logic [9:0] a,
                      input logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rv = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // An idle cycle follows, so no signal is set twice in one step.
      @(posedge pclk);
   endtask
   task automatic rdc(input logic [9:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rv, e);
   endtask
   // Fills a request block, starts it and polls until idle.
   task automatic blk(input logic [31:0] id, n, s, w3, w4);
      apb(1'b1, 10'h000, id);
      apb(1'b1, 10'h004, n);
      apb(1'b1, 10'h008, s);
      apb(1'b1, 10'h00c, w3);
      apb(1'b1, 10'h010, w4);
      apb(1'b1, A_CTRL, 32'h1);
      do apb(1'b0, A_CTRL, 32'h0); while (rv[0] !== 1'b0);
   endtask
   // Cycle watchdog and reboot pulse counter.
   always @(posedge pclk)
   begin
      cyc++;
      if (reboot === 1'b1)
         boots++;
      if (cyc == 40000)
      begin
         failures++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(A_CFG, RST_CFG);
      rdc(A_BAUD, 32'h4b00);
      apb(1'b1, A_BAUD, 32'h9600);
      rdc(A_BAUD, 32'h9600);
      apb(1'b0, 10'h200, 32'h0);
      chk({31'h0, er}, 32'h1);
      apb(1'b1, A_CFG, 32'hff00_0183);
      rdc(A_CFG, RST_CFG);
      apb(1'b0, A_STAT, 32'h0);
      chk({31'h0, rv[0]}, 32'h1);
      apb(1'b1, A_CFG, 32'h0500_0183);
      rdc(A_CFG, 32'h0500_0183);
      apb(1'b1, A_DBADDR, 32'h5);
      apb(1'b1, A_DBDATA, 32'h00f0);
      blk(ID_MASK, 32'h1, 32'h5, 32'h0ff0, 32'h0001);
      rdc(A_RSP0, ID_MASK);
      rdc(A_RSP1, ID_MASK);
      rdc(A_DBDATA, 32'h00f1);
      blk(ID_FORCE, 32'h2, 32'h9, 32'h1234, 32'h5678);
      rdc(A_RSP1, ID_FORCE);
      apb(1'b1, A_DBADDR, 32'ha);
      rdc(A_DBDATA, 32'h5678);
      msg_req <= 1'b1;
      for (i = 0; i < 500 && tx_start !== 1'b1; i++) @(posedge pclk);
      msg_req <= 1'b0;
      chk({31'h0, rts}, 32'h1);
      repeat (40) @(posedge pclk);
      rdc(A_STAT, 32'h2);
      apb(1'b1, A_CFG, 32'h0500_0182);
      rdc(A_CFG, 32'h0500_0182);
      blk(ID_WARM, 32'h0, 32'h0, 32'h0, 32'h0);
      rdc(A_RSP0, 32'h0);
      rdc(10'h000, 32'h0);
      chk(boots, 32'h1);
      give_verdict();
   end
endmodule
bind dbcmd_top dbcmd_monitor #(.MS_CYC(MS_CYC)) mon (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .prdata(prdata), .tx_start(tx_start), .rts(rts),
   .reboot(reboot), .port_cfg(port_cfg));
`default_nettype wire
